// [logic/breaker_fail_pickup_timing.sv]
`timescale 1ns/1ns
`default_nettype none

module breaker_fail_pickup_timing #(
    parameter int TICK_CYCLES = breaker_fail_pkg::PROGRAM_CYCLE_CLOCKS,
    parameter int MAG_W       = breaker_fail_pkg::MAG_W,
    parameter int DELAY_W     = breaker_fail_pkg::DELAY_W
) (
    input  wire logic                                   clock,
    input  wire logic                                   nrst,
    input  wire logic [MAG_W-1:0]                       phase_a_mag,
    input  wire logic [MAG_W-1:0]                       phase_b_mag,
    input  wire logic [MAG_W-1:0]                       phase_c_mag,
    input  wire logic [MAG_W-1:0]                       residual_input_one,
    input  wire logic [MAG_W-1:0]                       residual_input_two,
    input  wire logic [MAG_W-1:0]                       computed_residual,
    input  wire logic                                   output_relay_monitor,
    input  wire logic                                   binary_signal_monitor,
    input  wire logic                                   block_request,
    input  wire logic                                   force_enable,
    input  wire logic                                   force_block,
    input  wire logic [breaker_fail_pkg::PHASE_THR_W-1:0] phase_pickup_threshold,
    input  wire logic [MAG_W-1:0]                       residual_pickup_threshold,
    input  wire logic [1:0]                             residual_source_select,
    input  wire logic [3:0]                             operating_mode,
    input  wire logic                                   retrip_enable,
    input  wire logic [DELAY_W-1:0]                     retrip_delay,
    input  wire logic [DELAY_W-1:0]                     fail_delay,
    input  wire logic [2:0]                             logical_node_mode,
    output logic                                        program_tick,
    output logic                                        pickup,
    output logic                                        start,
    output logic                                        retrip,
    output logic                                        breaker_fail_trip,
    output logic                                        blocked,
    output logic [2:0]                                  condition,
    output logic [2:0]                                  logical_node_behaviour,
    output logic                                        block_event,
    output logic [MAG_W-1:0]                            event_phase_a,
    output logic [MAG_W-1:0]                            event_phase_b,
    output logic [MAG_W-1:0]                            event_phase_c,
    output logic [MAG_W-1:0]                            event_residual,
    output logic [3:0]                                  event_fault_type
);

    localparam int TICK_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

    logic [TICK_W-1:0]                          tick_count;
    logic                                       eval;
    logic [MAG_W-1:0]                           s_phase [3];
    logic [MAG_W-1:0]                           s_residual;
    logic                                       s_relay;
    logic                                       s_signal;
    logic                                       s_block;
    logic                                       s_force_en;
    logic                                       s_force_blk;
    logic [breaker_fail_pkg::PHASE_THR_W-1:0]   s_phase_thr;
    logic [MAG_W-1:0]                           s_res_thr;
    logic [1:0]                                 s_res_sel;
    logic [3:0]                                 s_mode;
    logic                                       s_retrip_en;
    logic [DELAY_W-1:0]                         s_retrip_delay;
    logic [DELAY_W-1:0]                         s_fail_delay;
    logic [2:0]                                 s_ln_mode;
    logic [3:0]                                 held;
    logic [3:0]                                 over;
    logic                                       current_pickup;
    logic                                       next_pickup;
    logic                                       block_now;
    breaker_fail_pkg::stage_t                   stage;
    breaker_fail_pkg::stage_t                   next_stage;
    logic [DELAY_W-1:0]                         elapsed;
    logic [DELAY_W-1:0]                         next_elapsed;

    // Picked-up channels compare against 97 percent; fresh ones against the full threshold.
    function automatic logic over_level(input logic [31:0] mag, input logic [31:0] thr,
                                        input logic was_held);
        if (was_held) begin
            over_level = (mag * breaker_fail_pkg::FULL_PERCENT) >=
                         (thr * breaker_fail_pkg::RELEASE_PERCENT);
        end else begin
            over_level = mag > thr;
        end
    endfunction

    function automatic logic mode_pickup(input logic [3:0] mode, input logic i,
                                         input logic d, input logic s);
        case (mode)
            breaker_fail_pkg::MODE_CURRENT:       mode_pickup = i;
            breaker_fail_pkg::MODE_RELAY:         mode_pickup = d;
            breaker_fail_pkg::MODE_SIGNALS:       mode_pickup = s;
            breaker_fail_pkg::MODE_CUR_AND_RELAY: mode_pickup = i & d;
            breaker_fail_pkg::MODE_CUR_OR_RELAY:  mode_pickup = i | d;
            breaker_fail_pkg::MODE_CUR_AND_SIG:   mode_pickup = i & s;
            breaker_fail_pkg::MODE_CUR_OR_SIG:    mode_pickup = i | s;
            breaker_fail_pkg::MODE_SIG_AND_RELAY: mode_pickup = s & d;
            breaker_fail_pkg::MODE_SIG_OR_RELAY:  mode_pickup = s | d;
            breaker_fail_pkg::MODE_ANY_OR:        mode_pickup = i | s | d;
            breaker_fail_pkg::MODE_ALL_AND:       mode_pickup = i & d & s;
            default:                              mode_pickup = 1'b0;
        endcase
    endfunction

    // Program cycle time base; the whole evaluation runs once per tick.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            tick_count   <= '0;
            program_tick <= 1'b0;
            eval         <= 1'b0;
        end else begin
            program_tick <= tick_count == TICK_W'(TICK_CYCLES - 1);
            tick_count   <= (tick_count == TICK_W'(TICK_CYCLES - 1)) ? '0 :
                            TICK_W'(tick_count + 1'b1);
            eval         <= program_tick;
        end
    end

    // Inputs and settings are taken one cycle before evaluation, so the block level used
    // is always the one seen at the start of the cycle.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            s_phase        <= '{default: '0};
            s_residual     <= '0;
            s_relay        <= 1'b0;
            s_signal       <= 1'b0;
            s_block        <= 1'b0;
            s_force_en     <= 1'b0;
            s_force_blk    <= 1'b0;
            s_phase_thr    <= breaker_fail_pkg::PHASE_THR_DEFAULT;
            s_res_thr      <= breaker_fail_pkg::RESIDUAL_THR_DEFAULT;
            s_res_sel      <= breaker_fail_pkg::SRC_UNUSED;
            s_mode         <= breaker_fail_pkg::MODE_CURRENT;
            s_retrip_en    <= 1'b1;
            s_retrip_delay <= breaker_fail_pkg::RETRIP_DELAY_DEFAULT;
            s_fail_delay   <= breaker_fail_pkg::FAIL_DELAY_DEFAULT;
            s_ln_mode      <= breaker_fail_pkg::LN_ON;
        end else if (program_tick) begin
            s_phase[0]     <= phase_a_mag;
            s_phase[1]     <= phase_b_mag;
            s_phase[2]     <= phase_c_mag;
            case (residual_source_select)
                breaker_fail_pkg::SRC_INPUT_ONE: s_residual <= residual_input_one;
                breaker_fail_pkg::SRC_INPUT_TWO: s_residual <= residual_input_two;
                breaker_fail_pkg::SRC_COMPUTED:  s_residual <= computed_residual;
                default:                         s_residual <= '0;
            endcase
            s_relay        <= output_relay_monitor;
            s_signal       <= binary_signal_monitor;
            s_block        <= block_request;
            s_force_en     <= force_enable;
            s_force_blk    <= force_block;
            s_phase_thr    <= phase_pickup_threshold;
            s_res_thr      <= residual_pickup_threshold;
            s_res_sel      <= residual_source_select;
            s_mode         <= operating_mode;
            s_retrip_en    <= retrip_enable;
            s_retrip_delay <= retrip_delay;
            s_fail_delay   <= fail_delay;
            s_ln_mode      <= logical_node_mode;
        end
    end

    always_comb begin
        for (int k = 0; k < 3; k++) begin
            over[k] = over_level(32'(s_phase[k]),
                                 32'(s_phase_thr) * breaker_fail_pkg::PHASE_TO_RESIDUAL,
                                 held[k]);
        end
        over[3] = (s_res_sel != breaker_fail_pkg::SRC_UNUSED) &&
                  over_level(32'(s_residual), 32'(s_res_thr), held[3]);
        current_pickup = |over;
        next_pickup = mode_pickup(s_mode, current_pickup, s_relay, s_signal) &&
                      (s_ln_mode != breaker_fail_pkg::LN_OFF);
        // Forcing only reaches the block path, so a commissioning test cannot trip a breaker.
        block_now = s_block || (s_force_en && s_force_blk) ||
                    (s_ln_mode == breaker_fail_pkg::LN_BLOCKED) ||
                    (s_ln_mode == breaker_fail_pkg::LN_TEST_BLOCKED);
    end

    always_comb begin
        next_stage = stage;
        case (stage)
            breaker_fail_pkg::STAGE_IDLE: begin
                if (next_pickup) begin
                    next_stage = block_now ? breaker_fail_pkg::STAGE_BLOCKED
                                           : breaker_fail_pkg::STAGE_STARTED;
                end
            end
            breaker_fail_pkg::STAGE_STARTED: begin
                if (!next_pickup) begin
                    next_stage = breaker_fail_pkg::STAGE_IDLE;
                end else if (block_now) begin
                    next_stage = breaker_fail_pkg::STAGE_BLOCKED;
                end
            end
            breaker_fail_pkg::STAGE_BLOCKED: begin
                if (!next_pickup) begin
                    next_stage = breaker_fail_pkg::STAGE_IDLE;
                end
            end
            default: next_stage = breaker_fail_pkg::STAGE_IDLE;
        endcase
        if (next_stage == breaker_fail_pkg::STAGE_STARTED &&
            stage == breaker_fail_pkg::STAGE_STARTED) begin
            next_elapsed = (elapsed == '1) ? elapsed : DELAY_W'(elapsed + 1'b1);
        end else begin
            next_elapsed = '0;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            held              <= '0;
            stage             <= breaker_fail_pkg::STAGE_IDLE;
            elapsed           <= '0;
            pickup            <= 1'b0;
            start             <= 1'b0;
            blocked           <= 1'b0;
            retrip            <= 1'b0;
            breaker_fail_trip <= 1'b0;
            condition         <= breaker_fail_pkg::COND_NORMAL;
        end else if (eval) begin
            held              <= over;
            stage             <= next_stage;
            elapsed           <= next_elapsed;
            pickup            <= next_pickup;
            start             <= next_stage == breaker_fail_pkg::STAGE_STARTED;
            blocked           <= next_stage == breaker_fail_pkg::STAGE_BLOCKED;
            retrip            <= s_retrip_en && (next_stage == breaker_fail_pkg::STAGE_STARTED)
                                 && (next_elapsed >= s_retrip_delay);
            breaker_fail_trip <= (next_stage == breaker_fail_pkg::STAGE_STARTED) &&
                                 (next_elapsed >= s_fail_delay);
            condition         <= (next_stage == breaker_fail_pkg::STAGE_BLOCKED)
                                 ? breaker_fail_pkg::COND_BLOCKED
                                 : (next_stage != breaker_fail_pkg::STAGE_STARTED)
                                 ? breaker_fail_pkg::COND_NORMAL
                                 : (next_elapsed >= s_fail_delay)
                                 ? breaker_fail_pkg::COND_FAIL_TRIP
                                 : (s_retrip_en && (next_elapsed >= s_retrip_delay))
                                 ? breaker_fail_pkg::COND_RETRIP
                                 : breaker_fail_pkg::COND_START;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            block_event      <= 1'b0;
            event_phase_a    <= '0;
            event_phase_b    <= '0;
            event_phase_c    <= '0;
            event_residual   <= '0;
            event_fault_type <= '0;
        end else begin
            block_event <= eval && (stage != breaker_fail_pkg::STAGE_BLOCKED) &&
                           (next_stage == breaker_fail_pkg::STAGE_BLOCKED);
            if (eval && (stage != breaker_fail_pkg::STAGE_BLOCKED) &&
                (next_stage == breaker_fail_pkg::STAGE_BLOCKED)) begin
                event_phase_a    <= s_phase[0];
                event_phase_b    <= s_phase[1];
                event_phase_c    <= s_phase[2];
                event_residual   <= s_residual;
                event_fault_type <= over;
            end
        end
    end

    assign logical_node_behaviour = s_ln_mode;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence seq_started;
        start;
    endsequence

    sequence seq_blocking;
        eval && next_pickup && block_now;
    endsequence

    start_not_blocked_a: assert property (start |-> !blocked)
        else $error("start and blocked both high");
    block_at_pickup_a: assert property (!start ##0 seq_blocking |=> blocked && !start)
        else $error("block at pick-up did not give blocked");
    block_drops_start_a: assert property (seq_started ##0 seq_blocking
                                          |=> !start && blocked && elapsed == '0)
        else $error("block during start did not release");
    timers_cleared_a: assert property (!start |-> elapsed == '0)
        else $error("timer not cleared without start");
    retrip_hidden_a: assert property (eval && !s_retrip_en |=> !retrip)
        else $error("retrip shown while disabled");
    retrip_delay_a: assert property ($rose(retrip) |-> start && elapsed >= s_retrip_delay)
        else $error("retrip before its delay");
    fail_delay_a: assert property ($rose(breaker_fail_trip)
                                   |-> start && elapsed >= s_fail_delay)
        else $error("fail trip before its delay");
    signal_no_delay_a: assert property (eval && s_mode == breaker_fail_pkg::MODE_SIGNALS
                                        && s_ln_mode != breaker_fail_pkg::LN_OFF
                                        |=> pickup == $past(s_signal))
        else $error("signal pick-up delayed");
    hysteresis_hold_a: assert property (eval && held[1] &&
                                        32'(s_phase[1]) * breaker_fail_pkg::FULL_PERCENT >=
                                        32'(s_phase_thr) * breaker_fail_pkg::PHASE_TO_RESIDUAL *
                                        breaker_fail_pkg::RELEASE_PERCENT |=> held[1])
        else $error("phase released above 97 percent");
    block_event_a: assert property (block_event |-> blocked && !$past(blocked))
        else $error("block event without new blocking");
    sample_first_a: assert property (eval |-> $past(program_tick))
        else $error("evaluation without sampling");
    fail_code_a: assert property (breaker_fail_trip |-> condition == breaker_fail_pkg::COND_FAIL_TRIP)
        else $error("condition code wrong on fail trip");

endmodule

`default_nettype wire

// [logic/breaker_fail_pkg.sv]
package breaker_fail_pkg;

    localparam int          CLOCK_PERIOD_NS        = 100;
    localparam int          PROGRAM_CYCLE_NS       = 5_000_000;
    localparam int          PROGRAM_CYCLE_CLOCKS   = PROGRAM_CYCLE_NS / CLOCK_PERIOD_NS;

    localparam int          MAG_W                  = 16;
    localparam int          PHASE_THR_W            = 13;
    localparam int          DELAY_W                = 19;

    localparam int          RELEASE_PERCENT        = 97;
    localparam int          FULL_PERCENT           = 100;
    localparam int          PHASE_TO_RESIDUAL      = 10;

    localparam int          DELAY_STEP_MS          = 5;
    localparam int          RETRIP_DELAY_MS        = 100;
    localparam int          FAIL_DELAY_MS          = 200;

    localparam logic [PHASE_THR_W-1:0] PHASE_THR_DEFAULT    = 13'h014;
    localparam logic [MAG_W-1:0]       RESIDUAL_THR_DEFAULT = 16'h04b0;
    localparam logic [DELAY_W-1:0]     RETRIP_DELAY_DEFAULT =
        DELAY_W'(RETRIP_DELAY_MS / DELAY_STEP_MS);
    localparam logic [DELAY_W-1:0]     FAIL_DELAY_DEFAULT   =
        DELAY_W'(FAIL_DELAY_MS / DELAY_STEP_MS);

    localparam logic [1:0]  SRC_UNUSED             = 2'h0;
    localparam logic [1:0]  SRC_INPUT_ONE          = 2'h1;
    localparam logic [1:0]  SRC_INPUT_TWO          = 2'h2;
    localparam logic [1:0]  SRC_COMPUTED           = 2'h3;

    localparam logic [3:0]  MODE_CURRENT           = 4'h0;
    localparam logic [3:0]  MODE_RELAY             = 4'h1;
    localparam logic [3:0]  MODE_SIGNALS           = 4'h2;
    localparam logic [3:0]  MODE_CUR_AND_RELAY     = 4'h3;
    localparam logic [3:0]  MODE_CUR_OR_RELAY      = 4'h4;
    localparam logic [3:0]  MODE_CUR_AND_SIG       = 4'h5;
    localparam logic [3:0]  MODE_CUR_OR_SIG        = 4'h6;
    localparam logic [3:0]  MODE_SIG_AND_RELAY     = 4'h7;
    localparam logic [3:0]  MODE_SIG_OR_RELAY      = 4'h8;
    localparam logic [3:0]  MODE_ANY_OR            = 4'h9;
    localparam logic [3:0]  MODE_ALL_AND           = 4'ha;

    localparam logic [2:0]  COND_NORMAL            = 3'h0;
    localparam logic [2:0]  COND_START             = 3'h1;
    localparam logic [2:0]  COND_RETRIP            = 3'h2;
    localparam logic [2:0]  COND_FAIL_TRIP         = 3'h3;
    localparam logic [2:0]  COND_BLOCKED           = 3'h4;

    localparam logic [2:0]  LN_ON                  = 3'h1;
    localparam logic [2:0]  LN_BLOCKED             = 3'h2;
    localparam logic [2:0]  LN_TEST                = 3'h3;
    localparam logic [2:0]  LN_TEST_BLOCKED        = 3'h4;
    localparam logic [2:0]  LN_OFF                 = 3'h5;

    typedef enum logic [1:0] {STAGE_IDLE, STAGE_STARTED, STAGE_BLOCKED} stage_t;

endpackage

// [verification/protection_partner.sv]
`timescale 1ns/1ns
`default_nettype none

// Far side of the stage: the monitored trip relay, a binary signal and the block source.
module protection_partner (
    input  wire logic trip_cmd,
    input  wire logic sig_cmd,
    input  wire logic block_cmd,
    output logic      relay_drive,
    output logic      signal_active,
    output logic      block_line
);
    // Combinational on purpose, since levels must settle before the next sampling tick.
    assign relay_drive   = trip_cmd;
    assign signal_active = sig_cmd;
    // The bench raises the block once while idle and once during a start, there after the retrip delay has run out but whole ticks ahead of the fail delay expiry.
    assign block_line    = block_cmd;
endmodule

`default_nettype wire

// [verification/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    logic        clock = 1'b0, nrst = 1'b0, program_tick, pickup, start, retrip, blocked;
    logic [15:0] phase_a_mag = 16'h0, phase_b_mag = 16'h0, phase_c_mag = 16'h0;
    logic [15:0] residual_input_one = 16'h0, residual_input_two = 16'h0;
    logic [15:0] computed_residual = 16'h0, residual_pickup_threshold = 16'h04b0;
    logic [15:0] event_phase_a, event_phase_b, event_phase_c, event_residual;
    logic [12:0] phase_pickup_threshold = 13'h014;
    logic [18:0] retrip_delay = 19'h3, fail_delay = 19'h6;
    logic [3:0]  operating_mode = 4'h0, event_fault_type;
    logic [2:0]  logical_node_mode = 3'h1, condition, logical_node_behaviour;
    logic [1:0]  residual_source_select = 2'h0;
    logic        trip_cmd = 1'b0, sig_cmd = 1'b0, block_cmd = 1'b0, retrip_enable = 1'b1;
    logic        force_enable = 1'b0, force_block = 1'b0, breaker_fail_trip, block_event, e;
    wire logic   output_relay_monitor, binary_signal_monitor, block_request;
    int          fails = 0, num_checks = 0, seed = 70398, cycles = 0, bev = 0, k, m, r;
    logic [15:0] hv [4] = '{16'h00c9, 16'h00c2, 16'h00c1, 16'h00c8};
    logic [2:0]  lm [5] = '{3'h1, 3'h3, 3'h2, 3'h4, 3'h5};

    protection_partner partner (.trip_cmd(trip_cmd), .sig_cmd(sig_cmd), .block_cmd(block_cmd),
        .relay_drive(output_relay_monitor), .signal_active(binary_signal_monitor),
        .block_line(block_request));
    breaker_fail_pickup_timing #(.TICK_CYCLES(16)) dut (
        .clock(clock), .nrst(nrst), .phase_a_mag(phase_a_mag), .phase_b_mag(phase_b_mag),
        .phase_c_mag(phase_c_mag), .residual_input_one(residual_input_one),
        .residual_input_two(residual_input_two), .computed_residual(computed_residual),
        .output_relay_monitor(output_relay_monitor), .block_request(block_request),
        .binary_signal_monitor(binary_signal_monitor), .force_enable(force_enable),
        .force_block(force_block), .phase_pickup_threshold(phase_pickup_threshold),
        .residual_pickup_threshold(residual_pickup_threshold), .retrip_enable(retrip_enable),
        .residual_source_select(residual_source_select), .operating_mode(operating_mode),
        .retrip_delay(retrip_delay), .fail_delay(fail_delay), .program_tick(program_tick),
        .logical_node_mode(logical_node_mode), .pickup(pickup), .start(start),
        .retrip(retrip), .breaker_fail_trip(breaker_fail_trip), .blocked(blocked),
        .condition(condition), .logical_node_behaviour(logical_node_behaviour),
        .block_event(block_event), .event_phase_a(event_phase_a),
        .event_phase_b(event_phase_b), .event_phase_c(event_phase_c),
        .event_residual(event_residual), .event_fault_type(event_fault_type));

    initial forever #50 clock = ~clock;
    always @(posedge clock) if (block_event === 1'b1) bev++;
    always @(posedge clock) begin
        cycles++;
        // The whole run needs under 1700 cycles, so this only trips on a hang.
        if (cycles == 5000) begin
            fails++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Stops at the falling edge inside a tick; inputs set here are sampled next.
    task automatic step();
        int n;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (program_tick !== 1'b1 && n < 40);
        if (n >= 40) fails++;
    endtask
    function automatic logic pk(input logic [3:0] md, input logic i, d, s);
        case (md)
            4'h0: return i;       4'h1: return d;       4'h2: return s;
            4'h3: return i & d;   4'h4: return i | d;   4'h5: return i & s;
            4'h6: return i | s;   4'h7: return s & d;   4'h8: return s | d;
            4'h9: return i | s | d;
            4'ha: return i & d & s;
            default: return 1'b0;
        endcase
    endfunction
    task automatic outs(input logic s, rt, t, b);
        chk(start, s);
        chk(retrip, rt);
        chk(breaker_fail_trip, t);
        chk(blocked, b);
        chk(condition, t ? 3'h3 : rt ? 3'h2 : s ? 3'h1 : b ? 3'h4 : 3'h0);
    endtask
    task automatic zero();
        {phase_a_mag, phase_b_mag, phase_c_mag} = 48'h0;
        {residual_input_one, residual_input_two, computed_residual} = 48'h0;
        {trip_cmd, sig_cmd, operating_mode, residual_source_select} = 8'h0;
        step();
    endtask

    initial begin
        repeat (8) @(negedge clock);
        nrst = 1'b1;
        @(negedge clock);
        chk(logical_node_behaviour, 3'h1);
        outs(0, 0, 0, 0);
        step();
        for (m = 0; m < 12; m++) for (r = 0; r < 4; r++) begin
            k = $random(seed);
            operating_mode = m[3:0];
            {sig_cmd, trip_cmd} = k[1:0];
            phase_a_mag = (k[2] && k[4:3] == 0) ? 16'h03e8 : 16'h0;
            phase_b_mag = (k[2] && k[4:3] == 1) ? 16'h03e8 : 16'h0;
            phase_c_mag = (k[2] && k[4] == 1) ? 16'h03e8 : 16'h0;
            residual_source_select = k[6:5];
            residual_input_one = k[7] ? 16'h0514 : 16'h0;
            residual_input_two = k[8] ? 16'h0514 : 16'h0;
            computed_residual = k[9] ? 16'h0514 : 16'h0;
            e = k[2] | (k[6:5] == 1 & k[7]) | (k[6:5] == 2 & k[8]) | (k[6:5] == 3 & k[9]);
            step();
            chk(pickup, pk(m[3:0], e, k[0], k[1]));
            chk(start, pk(m[3:0], e, k[0], k[1]));
        end
        zero();
        for (k = 0; k < 4; k++) begin
            phase_b_mag = hv[k];
            step();
            chk(pickup, k < 2);
        end
        zero();
        for (r = 0; r < 2; r++) begin
            retrip_enable = (r == 0);
            phase_a_mag = 16'h03e8;
            for (k = 0; k < 8; k++) begin
                step();
                outs(1, r == 0 && k >= 3, k >= 6, 0);
            end
            phase_a_mag = 16'h0;
            step();
            outs(0, 0, 0, 0);
        end
        block_cmd = 1'b1;
        step();
        {phase_a_mag, phase_c_mag} = 32'h0050_0320;
        {residual_source_select, residual_input_one} = {2'h1, 16'h0100};
        k = bev;
        step();
        outs(0, 0, 0, 1);
        chk(event_phase_c, 16'h0320);
        chk({event_phase_a, event_phase_b}, 32'h0050_0000);
        chk(event_residual, 16'h0100);
        chk(event_fault_type, 4'h4);
        chk(bev, k + 1);
        block_cmd = 1'b0;
        step();
        outs(0, 0, 0, 1);
        phase_c_mag = 16'h0;
        step();
        phase_a_mag = 16'h03e8;
        repeat (4) step();
        block_cmd = 1'b1;
        step();
        chk({start, retrip}, 2'b00);
        {block_cmd, phase_a_mag} = 17'h0;
        step();
        {force_enable, force_block, phase_a_mag} = {2'b11, 16'h03e8};
        step();
        chk({start, blocked}, 2'b01);
        zero();
        {force_enable, phase_a_mag} = {1'b0, 16'h03e8};
        step();
        chk({start, blocked}, 2'b10);
        for (k = 0; k < 5; k++) begin
            logical_node_mode = lm[k];
            step();
            chk(logical_node_behaviour, lm[k]);
            chk({pickup, start}, {k < 4, k < 2});
        end
        @(negedge clock);
        chk(program_tick, 1'b0);
        end_sim();
    end
endmodule

`default_nettype wire
